// ---- core/mebc_controller.sv ----
// Purpose: Multiplexed address/data external bus controller with four windows.
// Assumes: One 16-bit access per request; APB register slave with no wait states.
// Notes:   Read data passes a three-stage synchroniser before capture.
// Summary of operation
// - Window start comes from area bits 31-16, compared with access address 31-16.
// - Size code 0..8 halves from 16 Mbyte to 64 Kbyte; others prohibited.
// - Only start bits above the selected size are compared.
// - Overlapping enabled windows assert only the lowest-numbered select.
// - Select recovery field inserts none, 1, 2 or 4 dummy cycles.
// - Write and read recovery fields insert 0 to 6 or 8 dummy cycles.
// - Latch pulse width field gives 1, 2, 3 or 5 clocks.
// - At reset latch setting the strobe asserts two clocks after the address.
// - Read and write setup fields insert none, 1, 2 or 4 clocks.
// - Wait field inserts 0 to 31 internal wait clocks per access.
// - Width field: 00 selects 8-bit, 01 selects 16-bit data.
// - Control bit 0 enables a window; disabled windows never select.
// - A cycle with no setup, wait or recovery takes four clocks; this design takes the latch pulse width plus three.
// - Idle bus keeps upper address, no latch pulse, floats data, strobes off.
// - One bus cycle unit equals one system clock period.
// - Global stretch doubles or quadruples setup, wait and recovery cycles.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module mebc_controller (
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 reqValid,
    output logic                      reqReady,
    input  wire mebc_pkg::mebc_req_t  req,
    output logic                      rspValid,
    output logic                      rspMiss,
    output logic [15:0]               rspRdata,
    input  wire logic [15:0]          adIn,
    output mebc_pkg::mebc_pins_t      pins
);
    localparam int NW = mebc_pkg::NUM_WIN;

    logic [31:0]           modeReg_ff;
    logic [31:0]           areaReg_ff [NW];
    logic [31:0]           ctrlReg_ff [NW];
    logic [31:0]           prdata_ff;
    mebc_pkg::mebc_state_t state_ff;
    mebc_pkg::mebc_state_t nxt_state;
    logic [7:0]            cnt_ff;
    logic [7:0]            nxt_cnt;
    mebc_pkg::mebc_req_t   cur_ff;
    logic [1:0]            win_ff;
    logic                  holdEnd_ff;
    logic                  rspValid_ff;
    logic                  rspMiss_ff;
    logic [15:0]           rspRdata_ff;
    mebc_pkg::mebc_pins_t  pins_ff;
    mebc_pkg::mebc_pins_t  nxt_pins;
    logic [15:0]           adS1_ff;
    logic [15:0]           adS2_ff;
    logic [15:0]           adS3_ff;
    logic [15:0]           adStable_ff;
    logic                  hit;
    logic [1:0]            hitIdx;
    logic [NW-1:0]         winEn;

    // APB decode.
    wire        apbSetup  = psel && !penable;
    wire        apbWrite  = psel && penable && pwrite;
    wire [11:0] regOfs    = {paddr[11:2], 2'b00};
    wire        isMode    = (regOfs == mebc_pkg::OFS_MODE);
    wire        isStatus  = (regOfs == mebc_pkg::OFS_STATUS);
    wire        isArea    = (regOfs[11:4] == mebc_pkg::OFS_AREA0[11:4]);
    wire        isCtrl    = (regOfs[11:4] == mebc_pkg::OFS_CTRL0[11:4]);
    wire [1:0]  regIdx    = regOfs[3:2];
    wire        mapped    = isMode || isStatus || isArea || isCtrl;
    wire [31:0] statusVal = {29'h0, rspMiss_ff, (state_ff == mebc_pkg::ST_RECOV),
                             (state_ff != mebc_pkg::ST_IDLE)};
    wire [31:0] readVal   = isMode ? (modeReg_ff & mebc_pkg::MODE_WMASK) :
                            isArea ? (areaReg_ff[regIdx] & mebc_pkg::AREA_WMASK) :
                            isCtrl ? (ctrlReg_ff[regIdx] & mebc_pkg::CTRL_WMASK) :
                            isStatus ? statusVal : 32'h0000_0000;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_ff;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            prdata_ff  <= 32'h0000_0000;
            modeReg_ff <= mebc_pkg::MODE_RST;
        end else begin
            if (apbSetup) begin
                prdata_ff <= readVal;
            end
            if (apbWrite && isMode) begin
                modeReg_ff <= pwdata & mebc_pkg::MODE_WMASK;
            end
        end
    end

    for (genvar i = 0; i < NW; i++) begin : g_regs
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                areaReg_ff[i] <= mebc_pkg::AREA_RST;
                ctrlReg_ff[i] <= mebc_pkg::CTRL_RST;
            end else if (apbWrite && regIdx == 2'(i)) begin
                if (isArea) begin
                    areaReg_ff[i] <= pwdata & mebc_pkg::AREA_WMASK;
                end
                if (isCtrl) begin
                    ctrlReg_ff[i] <= pwdata & mebc_pkg::CTRL_WMASK;
                end
            end
        end
        assign winEn[i] = ctrlReg_ff[i][mebc_pkg::ENABLE_BIT];
    end

    mebc_window_decode #(
        .NUM_WIN (NW)
    ) u_decode (
        .addr    (req.addr),
        .areaReg (areaReg_ff),
        .winEn   (winEn),
        .hit     (hit),
        .winIdx  (hitIdx)
    );

    // Timing of the active cycle, taken from the selected window's control word.
    wire [31:0] ctl       = ctrlReg_ff[win_ff];
    wire [1:0]  stretch   = modeReg_ff[mebc_pkg::STRETCH_LSB +: 2];
    wire [1:0]  alewCode  = ctl[mebc_pkg::LATCH_PULSE_WIDTH_LSB +: 2];
    wire [7:0]  alewClk   = (alewCode == 2'h3) ? 8'h05 : {6'h00, alewCode} + 8'h01;
    wire [1:0]  setupCode = cur_ff.write ? ctl[mebc_pkg::WRS_LSB +: 2]
                                         : ctl[mebc_pkg::RDS_LSB +: 2];
    wire [7:0]  setupClk  = mebc_pkg::mebc_stretch(mebc_pkg::mebc_quad(setupCode), stretch);
    wire [7:0]  waitClk   = mebc_pkg::mebc_stretch({3'h0, ctl[mebc_pkg::WAIT_LSB +: 5]},
                                                   stretch);
    wire [2:0]  recCode   = cur_ff.write ? ctl[mebc_pkg::WRR_LSB +: 3]
                                         : ctl[mebc_pkg::RDR_LSB +: 3];
    wire [7:0]  recovClk  = mebc_pkg::mebc_stretch(
                                mebc_pkg::mebc_quad(ctl[mebc_pkg::CSR_LSB +: 2])
                                + mebc_pkg::mebc_recov(recCode), stretch);
    wire        wide      = (ctl[mebc_pkg::WIDTH_LSB +: 2] == mebc_pkg::WIDTH_16BIT);
    wire        cntDone   = (cnt_ff == 8'h00);
    wire        accept    = reqValid && reqReady;
    wire        holdEnd   = (state_ff == mebc_pkg::ST_HOLD) && cntDone;

    // Read data needs one more cycle through the synchroniser before the answer.
    assign reqReady = (state_ff == mebc_pkg::ST_IDLE) && !holdEnd_ff;

    // Each count holds its length minus one; one count step is one clk_sys period.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff - 8'h01;
        unique case (state_ff)
            mebc_pkg::ST_IDLE: begin
                nxt_cnt = 8'h00;
                if (accept && hit) begin
                    nxt_state = mebc_pkg::ST_ADDR;
                    nxt_cnt   = 8'h00;
                end
            end
            mebc_pkg::ST_ADDR: begin
                if (cntDone) begin
                    nxt_state = (setupClk != 8'h00) ? mebc_pkg::ST_SETUP : mebc_pkg::ST_STROBE;
                    nxt_cnt   = (setupClk != 8'h00) ? setupClk - 8'h01 : waitClk;
                end
            end
            mebc_pkg::ST_SETUP: begin
                if (cntDone) begin
                    nxt_state = mebc_pkg::ST_STROBE;
                    nxt_cnt   = waitClk + mebc_pkg::STROBE_BASE_CYC - 8'h01;
                end
            end
            mebc_pkg::ST_STROBE: begin
                if (cntDone) begin
                    nxt_state = mebc_pkg::ST_HOLD;
                    nxt_cnt   = mebc_pkg::HOLD_CYC - 8'h01;
                end
            end
            mebc_pkg::ST_HOLD: begin
                if (cntDone) begin
                    nxt_state = (recovClk != 8'h00) ? mebc_pkg::ST_RECOV : mebc_pkg::ST_IDLE;
                    nxt_cnt   = (recovClk != 8'h00) ? recovClk - 8'h01 : 8'h00;
                end
            end
            mebc_pkg::ST_RECOV: begin
                if (cntDone) begin
                    nxt_state = mebc_pkg::ST_IDLE;
                    nxt_cnt   = 8'h00;
                end
            end
            default: begin
                nxt_state = mebc_pkg::ST_IDLE;
                nxt_cnt   = 8'h00;
            end
        endcase
    end

    // The latch length is only known once the window is held, so ADDR loads it late.
    logic addrFirst_ff;
    wire  aleLong = addrFirst_ff && (alewClk != 8'h01);
    wire [7:0] cntLoad = (state_ff == mebc_pkg::ST_ADDR && cnt_ff == 8'h00 && addrFirst_ff)
                         ? alewClk - 8'h02 : nxt_cnt;
    mebc_pkg::mebc_state_t nxt_state_hold;

    // Address-latch length fix-up: hold ADDR for alewClk cycles in total.
    always_comb begin
        if (aleLong) begin
            nxt_state_hold = mebc_pkg::ST_ADDR;
        end else begin
            nxt_state_hold = nxt_state;
        end
    end

    // Pin values follow the next state so that they leave flip-flops.
    wire nxtActive = (nxt_state_hold inside {mebc_pkg::ST_ADDR, mebc_pkg::ST_SETUP,
                                             mebc_pkg::ST_STROBE, mebc_pkg::ST_HOLD});
    wire nxtData   = (nxt_state_hold inside {mebc_pkg::ST_SETUP, mebc_pkg::ST_STROBE,
                                             mebc_pkg::ST_HOLD});
    wire [31:0] nxtAddr  = accept ? req.addr : cur_ff.addr;
    wire        nxtWrite = accept ? req.write : cur_ff.write;
    wire [1:0]  nxtWin   = accept ? hitIdx : win_ff;
    wire [1:0]  nxtBe    = accept ? req.byteEn : cur_ff.byteEn;
    wire [31:0] nxtCtl   = ctrlReg_ff[nxtWin];
    wire        nxtWide  = (nxtCtl[mebc_pkg::WIDTH_LSB +: 2] == mebc_pkg::WIDTH_16BIT);

    always_comb begin
        nxt_pins        = pins_ff;
        nxt_pins.ale    = (nxt_state_hold == mebc_pkg::ST_ADDR);
        nxt_pins.adOeN  = 1'b1;
        nxt_pins.rdN    = !(nxt_state_hold == mebc_pkg::ST_STROBE && !nxtWrite);
        nxt_pins.wrN    = !(nxt_state_hold == mebc_pkg::ST_STROBE && nxtWrite);
        nxt_pins.csN    = 4'hF;
        nxt_pins.belN   = !(nxtActive && nxtBe[0]);
        nxt_pins.behN   = !(nxtActive && nxtBe[1] && nxtWide);
        if (nxtActive) begin
            nxt_pins.csN[nxtWin] = 1'b0;
        end
        if (nxt_state_hold == mebc_pkg::ST_ADDR) begin
            nxt_pins.ad     = nxtAddr[15:0];
            nxt_pins.addrHi = nxtAddr[23:16];
            nxt_pins.adOeN  = 1'b0;
        end else if (nxtData && nxtWrite) begin
            nxt_pins.ad    = cur_ff.wdata;
            nxt_pins.adOeN = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_ff     <= mebc_pkg::ST_IDLE;
            cnt_ff       <= 8'h00;
            addrFirst_ff <= 1'b0;
            cur_ff       <= '0;
            win_ff       <= 2'h0;
            pins_ff      <= '{ad: 16'h0000, adOeN: 1'b1, addrHi: 8'h00, ale: 1'b0,
                              rdN: 1'b1, wrN: 1'b1, csN: 4'hF, belN: 1'b1, behN: 1'b1};
        end else begin
            state_ff     <= nxt_state_hold;
            cnt_ff       <= aleLong ? cntLoad : nxt_cnt;
            addrFirst_ff <= accept && hit;
            pins_ff      <= nxt_pins;
            if (accept) begin
                cur_ff <= req;
                win_ff <= hitIdx;
            end
        end
    end

    // Read data synchroniser; a value counts once the second and third stages agree.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            adS1_ff     <= 16'h0000;
            adS2_ff     <= 16'h0000;
            adS3_ff     <= 16'h0000;
            adStable_ff <= 16'h0000;
        end else begin
            adS1_ff <= adIn;
            adS2_ff <= adS1_ff;
            adS3_ff <= adS2_ff;
            if (adS2_ff == adS3_ff) begin
                adStable_ff <= adS3_ff;
            end
        end
    end

    // The strobe data reaches the last two stages one cycle after the hold ends.
    wire [15:0] adNow = (adS2_ff == adS3_ff) ? adS3_ff : adStable_ff;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            holdEnd_ff  <= 1'b0;
            rspValid_ff <= 1'b0;
            rspMiss_ff  <= 1'b0;
            rspRdata_ff <= 16'h0000;
        end else begin
            holdEnd_ff  <= holdEnd;
            rspValid_ff <= holdEnd_ff || (accept && !hit);
            if (accept && !hit) begin
                rspMiss_ff <= 1'b1;
            end else if (holdEnd_ff) begin
                rspMiss_ff  <= 1'b0;
                rspRdata_ff <= cur_ff.write ? rspRdata_ff
                             : (wide ? adNow : {8'h00, adNow[7:0]});
            end
        end
    end

    assign rspValid = rspValid_ff;
    assign rspMiss  = rspMiss_ff;
    assign rspRdata = rspRdata_ff;
    assign pins     = pins_ff;

    // Checks.
    logic [7:0] aleLen_ff;
    logic [7:0] cycLen_ff;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            aleLen_ff <= 8'h00;
            cycLen_ff <= 8'h00;
        end else begin
            aleLen_ff <= pins_ff.ale ? aleLen_ff + 8'h01 : 8'h00;
            cycLen_ff <= (state_ff == mebc_pkg::ST_IDLE || state_ff == mebc_pkg::ST_RECOV)
                         ? 8'h00 : cycLen_ff + 8'h01;
        end
    end

    sequence s_aleStart;
        $rose(pins_ff.ale) && alewCode == 2'h1 && setupClk == 8'h00;
    endsequence
    property p_strobeAfterAle;
        @(posedge clk_sys) disable iff (!nrst)
        s_aleStart |-> ##2 (!pins_ff.rdN || !pins_ff.wrN);
    endproperty
    a_strobeAfterAle: assert property (p_strobeAfterAle) else $error("strobe late");

    property p_aleWidth;
        @(posedge clk_sys) disable iff (!nrst)
        $fell(pins_ff.ale) |-> aleLen_ff == alewClk;
    endproperty
    a_aleWidth: assert property (p_aleWidth) else $error("latch width wrong");

    property p_cycleLen;
        @(posedge clk_sys) disable iff (!nrst)
        holdEnd |-> cycLen_ff + 8'h01 == alewClk + setupClk + waitClk + 8'h03;
    endproperty
    a_cycleLen: assert property (p_cycleLen) else $error("cycle length wrong");

    property p_oneSelect;
        @(posedge clk_sys) disable iff (!nrst)
        $onehot0(~pins_ff.csN) && (pins_ff.csN == 4'hF || winEn[win_ff]);
    endproperty
    a_oneSelect: assert property (p_oneSelect) else $error("bad select");

    property p_missNoCycle;
        @(posedge clk_sys) disable iff (!nrst)
        accept && !hit |=> rspValid && rspMiss && state_ff == mebc_pkg::ST_IDLE
                           && pins_ff.csN == 4'hF;
    endproperty
    a_missNoCycle: assert property (p_missNoCycle) else $error("miss started cycle");

    property p_idlePins;
        @(posedge clk_sys) disable iff (!nrst)
        state_ff == mebc_pkg::ST_IDLE && $past(state_ff) == mebc_pkg::ST_IDLE
        |-> pins_ff.adOeN && pins_ff.rdN && pins_ff.wrN && !pins_ff.ale
            && $stable(pins_ff.addrHi);
    endproperty
    a_idlePins: assert property (p_idlePins) else $error("idle pins active");

    property p_recovery;
        @(posedge clk_sys) disable iff (!nrst)
        holdEnd && recovClk == 8'h01 |=> state_ff == mebc_pkg::ST_RECOV
                                        ##1 state_ff == mebc_pkg::ST_IDLE;
    endproperty
    a_recovery: assert property (p_recovery) else $error("recovery wrong");

    property p_narrowHigh;
        @(posedge clk_sys) disable iff (!nrst)
        !pins_ff.wrN && !wide |-> pins_ff.behN;
    endproperty
    a_narrowHigh: assert property (p_narrowHigh) else $error("high lane on 8-bit");
endmodule

// ---- core/mebc_pkg.sv ----
// Purpose: Shared constants and types for the multiplexed external bus controller.
// Assumes: 32-bit APB register access, 100 MHz system clock.
// Notes:   Offsets are byte addresses on the APB register bus.
package mebc_pkg;
    localparam int NUM_WIN = 4;

    localparam logic [11:0] OFS_MODE   = 12'h000;
    localparam logic [11:0] OFS_AREA0  = 12'h010;
    localparam logic [11:0] OFS_CTRL0  = 12'h040;
    localparam logic [11:0] OFS_STATUS = 12'h080;

    localparam logic [31:0] MODE_RST   = 32'h0000_0000;
    localparam logic [31:0] AREA_RST   = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST   = 32'h4915_0202;
    localparam logic [31:0] MODE_WMASK = 32'h0000_0007;
    localparam logic [31:0] AREA_WMASK = 32'hFFFF_00FF;
    localparam logic [31:0] CTRL_WMASK = 32'hFF3F_1F07;

    localparam int MODE_SEL_BIT = 0;
    localparam int STRETCH_LSB  = 1;
    localparam int START_LSB    = 16;
    localparam int SIZE_LSB     = 0;
    localparam int CSR_LSB      = 30;
    localparam int WRR_LSB      = 27;
    localparam int RDR_LSB      = 24;
    localparam int LATCH_PULSE_WIDTH_LSB     = 20;
    localparam int WRS_LSB      = 18;
    localparam int RDS_LSB      = 16;
    localparam int WAIT_LSB     = 8;
    localparam int WIDTH_LSB    = 1;
    localparam int ENABLE_BIT   = 0;

    localparam logic [7:0] SIZE_MAX_CODE  = 8'h08;
    localparam logic [1:0] WIDTH_8BIT     = 2'h0;
    localparam logic [1:0] WIDTH_16BIT    = 2'h1;
    localparam logic [7:0] STROBE_BASE_CYC = 8'h01;
    localparam logic [7:0] HOLD_CYC        = 8'h02;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_ADDR   = 6'h02,
        ST_SETUP  = 6'h04,
        ST_STROBE = 6'h08,
        ST_HOLD   = 6'h10,
        ST_RECOV  = 6'h20
    } mebc_state_t;

    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic [15:0] wdata;
        logic [1:0]  byteEn;
    } mebc_req_t;

    typedef struct packed {
        logic [15:0] ad;
        logic        adOeN;
        logic [7:0]  addrHi;
        logic        ale;
        logic        rdN;
        logic        wrN;
        logic [3:0]  csN;
        logic        belN;
        logic        behN;
    } mebc_pins_t;

    // Codes 00..11 give 0, 1, 2 and 4 cycles.
    function automatic logic [7:0] mebc_quad(input logic [1:0] code);
        return (code == 2'h3) ? 8'h04 : {6'h00, code};
    endfunction

    // Codes 000..110 give 0..6 cycles, 111 gives 8.
    function automatic logic [7:0] mebc_recov(input logic [2:0] code);
        return (code == 3'h7) ? 8'h08 : {5'h00, code};
    endfunction

    // Stretch code 11 is prohibited and is treated as no stretch.
    function automatic logic [7:0] mebc_stretch(input logic [7:0] n, input logic [1:0] code);
        return (code == 2'h3) ? n : 8'(n << code);
    endfunction
endpackage

// ---- core/mebc_window_decode.sv ----
// Purpose: Chip-select window match with fixed priority.
// Assumes: Start fields sit in bits 31..16 and size codes in bits 7..0.
// Notes:   Prohibited size codes never match.
`timescale 1ns/100ps
module mebc_window_decode #(
    parameter int NUM_WIN = mebc_pkg::NUM_WIN
) (
    input  wire logic [31:0]                addr,
    input  wire logic [31:0]                areaReg [NUM_WIN],
    input  wire logic [NUM_WIN-1:0]         winEn,
    output logic                            hit,
    output logic [$clog2(NUM_WIN)-1:0]      winIdx
);
    logic [NUM_WIN-1:0] match;

    for (genvar i = 0; i < NUM_WIN; i++) begin : g_match
        wire [7:0]  sizeCode = areaReg[i][mebc_pkg::SIZE_LSB +: 8];
        wire [15:0] cmpMask  = ~(16'h00FF >> sizeCode[3:0]);
        wire [15:0] diff     = addr[31:16] ^ areaReg[i][mebc_pkg::START_LSB +: 16];
        assign match[i] = winEn[i] && (sizeCode <= mebc_pkg::SIZE_MAX_CODE)
                          && ((diff & cmpMask) == 16'h0000);
    end

    assign hit = |match;

    always_comb begin
        winIdx = '0;
        for (int i = NUM_WIN - 1; i >= 0; i--) begin
            if (match[i]) begin
                winIdx = ($clog2(NUM_WIN))'(i);
            end
        end
    end
endmodule

// ---- dv/mebc_ext_mem.sv ----
// Purpose: Memory model that sits on the multiplexed external bus.
// Assumes: Address is latched while ale is high.
// Notes:   Read data is the latched address XOR a pattern; lines toggle when released.
`timescale 1ns/100ps
module mebc_ext_mem (
    input  wire logic                 clk_sys,
    input  wire mebc_pkg::mebc_pins_t pins,
    output logic [15:0]               adIn,
    output logic [15:0]               wrData
);
    logic [15:0] latAddr_ff = 16'h0000;
    logic [15:0] last_ff    = 16'h0000;
    logic        rdSeen_ff  = 1'b0;
    wire         driving    = rdSeen_ff || !pins.rdN;
    // Released lines invert every cycle so a stale value never looks valid.
    assign adIn = driving ? (latAddr_ff ^ 16'hA5C3) : ~last_ff;
    always_ff @(posedge clk_sys) begin
        if (pins.ale) latAddr_ff <= pins.ad;
        if (!pins.wrN) wrData <= pins.ad;
        rdSeen_ff <= driving && (pins.csN != 4'hF);
        last_ff   <= adIn;
    end
endmodule

// ---- dv/tb_mebc_controller.sv ----
// Purpose: Self-checking bench for the external bus controller.
// Assumes: APB slave with no wait states; memory model on the pins.
// Notes:   Cycle counts run from the request edge to the answer, one past the hold end.
`timescale 1ns/100ps
module tb_mebc_controller;
    localparam logic [11:0] A0 = mebc_pkg::OFS_AREA0;
    localparam logic [11:0] C0 = mebc_pkg::OFS_CTRL0;
    logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, slv, reqValid = 1'b0, reqReady, rspValid, rspMiss;
    mebc_pkg::mebc_req_t req = '0;
    mebc_pkg::mebc_pins_t pins;
    logic [15:0] rspRdata, adIn, wrData;
    logic [3:0] cs;
    int num_errors = 0, checked = 0, n, w, w0;
    int alw [4] = '{1, 2, 3, 5};
    always #5 clk_sys = ~clk_sys;
    mebc_controller i_dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reqValid(reqValid), .reqReady(reqReady), .req(req),
        .rspValid(rspValid), .rspMiss(rspMiss), .rspRdata(rspRdata), .adIn(adIn), .pins(pins));
    mebc_ext_mem i_mem (.clk_sys(clk_sys), .pins(pins), .adIn(adIn), .wrData(wrData));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    // Whole 32-bit words only; request held until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rr(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", e, q);
    endtask
    task automatic acc(input logic wr, input logic [31:0] a, input logic [15:0] d);
        w = 0;
        n = 0;
        cs = 4'hF;
        reqValid <= 1'b1;
        req      <= '{wr, a, d, 2'h3};
        @(negedge clk_sys);
        while (reqReady !== 1'b1 && w < 999) begin
            w++;
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        reqValid <= 1'b0;
        do begin
            @(negedge clk_sys);
            n++;
            cs &= pins.csN;
        end while (rspValid !== 1'b1 && n < 99);
        if (w >= 999 || n >= 99) num_errors++;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [31:0] a, input int en, input logic [15:0] ed,
                      input logic [3:0] ec);
        acc(1'b0, a, 16'h0000);
        chk("cycles", en, n);
        chk("select", ec, cs);
        chk("miss", {31'h0, ec == 4'hF}, {31'h0, rspMiss});
        if (ec != 4'hF) chk("rdata", ed, rspRdata);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        rr(A0, 32'h0);
        rr(C0 + 12'h4, 32'h4915_0202);
        apb(1'b1, C0 + 12'h8, 32'hFFFF_FFFE);
        rr(C0 + 12'h8, 32'hFF3F_1F06);
        apb(1'b1, A0 + 12'hC, 32'hFFFF_FFFF);
        rr(A0 + 12'hC, 32'hFFFF_00FF);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped", 32'h1, {31'h0, slv});
        apb(1'b1, 12'h000, 32'h0);
        $display("register test done");
        rd(32'h6012_1234, 1, 16'h0, 4'hF);
        apb(1'b1, A0, 32'h6012_0008);
        apb(1'b1, C0, 32'h0000_0003);
        rd(32'h6012_1234, 6, 16'h1234 ^ 16'hA5C3, 4'hE);
        acc(1'b1, 32'h6012_0042, 16'hBEEF);
        chk("write cycles", 6, n);
        chk("write data", 32'hBEEF, {16'h0, wrData});
        rd(32'h6013_0000, 1, 16'h0, 4'hF);
        chk("idle pins", 32'h024E, {19'h0, pins.addrHi, pins.ale, pins.rdN, pins.wrN,
            pins.adOeN, 1'b0});
        apb(1'b1, A0, 32'h6000_0000);
        rd(32'h60FF_0000, 6, 16'hA5C3, 4'hE);
        apb(1'b1, A0 + 12'h4, 32'h60FF_0008);
        apb(1'b1, C0 + 12'h4, 32'h0000_0003);
        rd(32'h60FF_0010, 6, 16'h0010 ^ 16'hA5C3, 4'hE);
        apb(1'b1, C0, 32'h0000_0002);
        rd(32'h60FF_0010, 6, 16'h0010 ^ 16'hA5C3, 4'hD);
        apb(1'b1, C0 + 12'h4, 32'h0000_0001);
        rd(32'h60FF_00AB, 6, 16'h0068, 4'hD);
        $display("decode test done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, C0 + 12'h4, {10'h0, 2'(k), 20'h0_0003});
            rd(32'h60FF_0002, alw[k] + 5, 16'hA5C1, 4'hD);
        end
        apb(1'b1, 12'h000, 32'h0000_0002);
        apb(1'b1, C0 + 12'h4, 32'h0003_0303);
        rd(32'h60FF_0002, 20, 16'hA5C1, 4'hD);
        apb(1'b1, 12'h000, 32'h0);
        $display("timing test done");
        apb(1'b1, C0 + 12'h4, 32'h0000_0003);
        acc(1'b0, 32'h60FF_0000, 16'h0);
        acc(1'b0, 32'h60FF_0000, 16'h0);
        w0 = w;
        apb(1'b1, C0 + 12'h4, 32'hC700_0003);
        acc(1'b0, 32'h60FF_0000, 16'h0);
        acc(1'b0, 32'h60FF_0000, 16'h0);
        // The next request is seen two cycles after the hold ends.
        chk("read recovery", 12 - 2, w - w0);
        apb(1'b1, C0 + 12'h4, 32'hA800_0003);
        acc(1'b1, 32'h60FF_0000, 16'h1111);
        acc(1'b1, 32'h60FF_0000, 16'h2222);
        chk("write recovery", 7 - 2, w - w0);
        $display("recovery test done");
        give_verdict();
    end
endmodule
